// ### dv/bridge_load.sv
`timescale 1ns/1ps
module bridge_load (
  input  wire pwm_stage_pkg::bridge_pins_type pins,
  output logic [3:0]                          wire_level
);
  import pwm_stage_pkg::*;
  // ****************************************
  // Gate drivers with pull-downs
  // ****************************************
  // Released pins fall to the pull-downs, so the switches stay off
  assign wire_level = pins.level & ~pins.oe_n;
endmodule : bridge_load

// ### dv/tb_pwm_deadband_autoshutdown.sv
`timescale 1ns/1ps
module tb_pwm_deadband_autoshutdown;
  import pwm_stage_pkg::*;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic                aclk = 1'b0;
  logic                aresetn, clk_en, period_start, pwm_modulated, irq;
  logic                s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                s_axi_rvalid, s_axi_rready;
  logic [7:0]          s_axi_awaddr, s_axi_araddr;
  logic [31:0]         s_axi_wdata, s_axi_rdata;
  logic [3:0]          s_axi_wstrb, wl;
  logic [1:0]          s_axi_bresp, s_axi_rresp, output_config_select, output_polarity_select;
  shutdown_inputs_type shutdown_inputs;
  bridge_pins_type     bridge_pins;
  int                  n_mismatch, checked, cyc, t0;

  pwm_deadband_autoshutdown dut (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .period_start, .pwm_modulated,
    .output_config_select, .output_polarity_select, .shutdown_inputs, .bridge_pins, .irq);
  bridge_load load (.pins(bridge_pins), .wire_level(wl));

  always #2.5 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er);
    bit ka;
    bit kw;
    @(posedge aclk);
    ka = 1'b0;
    kw = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      ka = ka | s_axi_awready;
      kw = kw | s_axi_wready;
      if (ka) s_axi_awvalid <= 1'b0;
      if (kw) s_axi_wvalid <= 1'b0;
    end while (!(ka && kw));
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    chk("bresp", er, s_axi_bresp);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er,
                    input logic [31:0] m = 32'hffff_ffff);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    chk("rdata", e, s_axi_rdata & m);
    chk("rresp", er, s_axi_rresp);
  endtask : rd

  // Cycles from t0 until pin i shows v, capped at 200
  task automatic arrive(input int i, input logic v, input int e);
    do begin
      @(posedge aclk);
      #1;
    end while (wl[i] !== v && cyc < t0 + 200);
    chk("delay", e, cyc - t0);
  endtask : arrive

  task automatic period;
    @(posedge aclk);
    period_start <= 1'b1;
    @(posedge aclk);
    period_start <= 1'b0;
    @(posedge aclk);
    #1;
  endtask : period

  task automatic finish_test;
    if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test

  initial begin
    repeat (5000) @(posedge aclk);
    n_mismatch++;
    finish_test();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    {aresetn, period_start, pwm_modulated, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, shutdown_inputs} = '0;
    {clk_en, s_axi_bready, s_axi_rready} = 3'h7;
    s_axi_wstrb = 4'h1;
    output_config_select = MODE_HALF_BRIDGE;
    output_polarity_select = 2'h0;
    {n_mismatch, checked} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFFSET_RESTART_AND_DEADBAND, 32'h0, RESP_OKAY);
    rd(OFFSET_SHUTDOWN_CONTROL, 32'h0, RESP_OKAY);
    rd(8'h14, 32'h0, RESP_SLVERR);
    wr(8'h14, 8'h5a, RESP_SLVERR);
    wr(OFFSET_RESTART_AND_DEADBAND, 8'h03, RESP_OKAY);
    rd(OFFSET_RESTART_AND_DEADBAND, 32'h03, RESP_OKAY);
    @(posedge aclk);
    pwm_modulated <= 1'b1;
    t0 = cyc + 1;
    arrive(1, 1'b0, 1);
    arrive(0, 1'b1, 4);
    @(posedge aclk);
    pwm_modulated <= 1'b0;
    t0 = cyc + 1;
    arrive(0, 1'b0, 1);
    arrive(1, 1'b1, 4);
    @(posedge aclk);
    pwm_modulated <= 1'b1;
    repeat (2) @(posedge aclk);
    pwm_modulated <= 1'b0;
    t0 = cyc;
    arrive(0, 1'b1, 200);
    @(posedge aclk);
    output_polarity_select <= 2'h2;
    repeat (3) @(posedge aclk);
    chk("polarity", 32'h1, wl[0]);
    output_polarity_select <= 2'h0;
    wr(OFFSET_IRQ_MASK, 8'h01, RESP_OKAY);
    wr(OFFSET_SHUTDOWN_CONTROL, 8'h14, RESP_OKAY);
    @(posedge aclk);
    shutdown_inputs <= 3'b100;
    #1;
    chk("forced", 32'h50, bridge_pins);
    rd(OFFSET_SHUTDOWN_CONTROL, 32'h94, RESP_OKAY);
    chk("irq", 32'h1, irq);
    wr(OFFSET_SHUTDOWN_CONTROL, 8'h14, RESP_OKAY);
    rd(OFFSET_SHUTDOWN_CONTROL, 32'h94, RESP_OKAY);
    shutdown_inputs <= 3'b000;
    rd(OFFSET_SHUTDOWN_CONTROL, 32'h94, RESP_OKAY);
    wr(OFFSET_SHUTDOWN_CONTROL, 8'h14, RESP_OKAY);
    rd(OFFSET_SHUTDOWN_CONTROL, 32'h14, RESP_OKAY);
    chk("held", 32'h50, bridge_pins);
    period();
    chk("resume", 32'h2, wl[1:0]);
    rd(OFFSET_IRQ_STATUS, 32'h3, RESP_OKAY);
    wr(OFFSET_IRQ_STATUS, 8'h03, RESP_OKAY);
    rd(OFFSET_IRQ_STATUS, 32'h0, RESP_OKAY);
    chk("irq", 32'h0, irq);
    wr(OFFSET_IRQ_MASK, 8'h02, RESP_OKAY);
    wr(OFFSET_RESTART_AND_DEADBAND, 8'h83, RESP_OKAY);
    wr(OFFSET_SHUTDOWN_CONTROL, 8'h49, RESP_OKAY);
    @(posedge aclk);
    shutdown_inputs <= 3'b001;
    #1;
    chk("released", 32'ha5, {wl, bridge_pins.oe_n});
    rd(OFFSET_SHUTDOWN_CONTROL, 32'hc9, RESP_OKAY);
    chk("irq_masked", 32'h0, irq);
    shutdown_inputs <= 3'b000;
    rd(OFFSET_SHUTDOWN_CONTROL, 32'h49, RESP_OKAY);
    chk("held", 32'ha5, {wl, bridge_pins.oe_n});
    period();
    chk("irq", 32'h1, irq);
    wr(OFFSET_SHUTDOWN_CONTROL, 8'hc9, RESP_OKAY);
    chk("software", 32'ha5, {wl, bridge_pins.oe_n});
    period();
    chk("restart", 32'h20, {wl, bridge_pins.oe_n});
    @(posedge aclk);
    output_config_select <= MODE_FULL_FORWARD;
    pwm_modulated <= 1'b1;
    t0 = cyc + 1;
    arrive(3, 1'b1, 1);
    chk("forward", 32'h9, wl);
    @(posedge aclk);
    output_config_select <= MODE_FULL_REVERSE;
    t0 = cyc + 1;
    arrive(1, 1'b1, 1);
    chk("reverse", 32'h6, wl);
    @(posedge aclk);
    output_config_select <= MODE_SINGLE;
    repeat (2) @(posedge aclk);
    chk("single", 32'h1, wl);
    clk_en <= 1'b0;
    pwm_modulated <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("frozen", 32'h1, {s_axi_awready, wl});
    clk_en <= 1'b1;
    output_config_select <= MODE_HALF_BRIDGE;
    s_axi_wstrb <= 4'h0;
    wr(OFFSET_IRQ_MASK, 8'h03, RESP_OKAY);
    rd(OFFSET_IRQ_MASK, 32'h2, RESP_OKAY);
    s_axi_wstrb <= 4'h1;
    for (int s = 0; s < 8; s++) begin
      for (int j = 0; j < 3; j++) begin
        wr(OFFSET_SHUTDOWN_CONTROL, {1'b0, s[2:0], 4'h0}, RESP_OKAY);
        shutdown_inputs <= {j == 0, j == 1, j == 2};
        rd(OFFSET_PIN_STATE, {22'h0, s != 7 && s[j], 9'h0}, RESP_OKAY, 32'h200);
        shutdown_inputs <= 3'b000;
      end
    end
    finish_test();
  end
endmodule : tb_pwm_deadband_autoshutdown

// ### src/deadband_delay.sv
`timescale 1ns/1ps
module deadband_delay #(
  parameter int WIDTH = 7
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             clk_en,
  input  wire logic             enable,
  input  wire logic [WIDTH-1:0] count,
  input  wire logic             active_in,
  output logic                  active_out
);
  logic [WIDTH-1:0] elapsed;

  // Only the rising edge waits; a pulse shorter than the count never shows
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      elapsed <= '0;
    end else if (clk_en) begin
      if (!active_in) begin
        elapsed <= '0;
      end else if (elapsed != count) begin
        elapsed <= elapsed + WIDTH'(1);
      end
    end
  end

  assign active_out = active_in & (!enable | (elapsed == count));

endmodule : deadband_delay

// ### src/pair_driver.sv
`timescale 1ns/1ps
module pair_driver
  import pwm_stage_pkg::*;
(
  input  wire logic       [1:0] normal,
  input  wire logic             invert,
  input  wire logic             force_shutdown,
  input  wire logic       [1:0] shutdown_state,
  output logic            [1:0] level,
  output logic            [1:0] oe_n
);
  wire logic tristate = force_shutdown & shutdown_state[1];
  wire logic drive_hi = (shutdown_state == STATE_DRIVE_HIGH);

  assign level = force_shutdown ? {2{drive_hi}} : (normal ^ {2{invert}});
  assign oe_n  = {2{tristate}};

endmodule : pair_driver

// ### src/pwm_deadband_autoshutdown.sv
`timescale 1ns/1ps
// Overview of operation
// - Half-bridge: delay only inactive-to-active edges
// - Seven-bit dead-band count in instruction cycles
// - Shutdown forces pins immediately, no clock
// - Three-bit field selects comparator/fault sources
// - Per-pair state: low, high, or tri-state
// - Hardware sets status; status holds shutdown
// - Restart enabled: status clears when cause ends
// - Restart disabled: status stays until software
// - Resume only at next period start
// - Status writes ignored while cause active
// - Comparator cause blocks any status clear
// - Writing one to status forces shutdown
// - Restart enable is delay register bit seven
// - Polarity bits invert A/C and B/D pairs
// - Enable pins after one full period; pins drive from reset here
// - Count beyond duty keeps output inactive
// - Half: A is PWM, B complement; full: no delay
module pwm_deadband_autoshutdown
  import pwm_stage_pkg::*;
#(
  parameter int ADDR_WIDTH = 8
) (
  input  wire logic                            aclk,
  input  wire logic                            aresetn,
  input  wire logic                            clk_en,
  input  wire logic         [ADDR_WIDTH-1:0]   s_axi_awaddr,
  input  wire logic                            s_axi_awvalid,
  output logic                                 s_axi_awready,
  input  wire logic         [31:0]             s_axi_wdata,
  input  wire logic         [3:0]              s_axi_wstrb,
  input  wire logic                            s_axi_wvalid,
  output logic                                 s_axi_wready,
  output logic              [1:0]              s_axi_bresp,
  output logic                                 s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  input  wire logic         [ADDR_WIDTH-1:0]   s_axi_araddr,
  input  wire logic                            s_axi_arvalid,
  output logic                                 s_axi_arready,
  output logic              [31:0]             s_axi_rdata,
  output logic              [1:0]              s_axi_rresp,
  output logic                                 s_axi_rvalid,
  input  wire logic                            s_axi_rready,
  input  wire logic                            period_start,
  input  wire logic                            pwm_modulated,
  input  wire logic         [1:0]              output_config_select,
  input  wire logic         [1:0]              output_polarity_select,
  input  wire pwm_stage_pkg::shutdown_inputs_type shutdown_inputs,
  output pwm_stage_pkg::bridge_pins_type       bridge_pins,
  output logic                                 irq
);
  import pwm_stage_pkg::*;

  // ****************************************************************
  // Register and state storage
  // ****************************************************************
  logic [7:0]           pwm_restart_and_deadband;
  logic [7:0]           pwm_shutdown_control;
  logic [IRQ_WIDTH-1:0] irq_status;
  logic [IRQ_WIDTH-1:0] irq_mask;
  run_state_type        run_state;
  logic [3:0]           normal;

  logic                  aw_held;
  logic                  w_held;
  logic [ADDR_WIDTH-1:0] aw_addr;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;

  // ****************************************************************
  // Field views
  // ****************************************************************
  wire logic                      restart_enable = pwm_restart_and_deadband[RESTART_ENABLE_BIT];
  wire logic [DEADBAND_WIDTH-1:0] deadband_count =
    pwm_restart_and_deadband[DEADBAND_WIDTH-1:0];
  wire logic       shutdown_status        = pwm_shutdown_control[SHUTDOWN_STATUS_BIT];
  wire logic [2:0] shutdown_source_select = pwm_shutdown_control[SOURCE_LSB +: 3];
  wire logic [1:0] pair_ac_shutdown_state = pwm_shutdown_control[PAIR_AC_LSB +: 2];
  wire logic [1:0] pair_bd_shutdown_state = pwm_shutdown_control[PAIR_BD_LSB +: 2];

  // ****************************************************************
  // AXI4-Lite write path
  // ****************************************************************
  wire logic write_fire = aw_held & w_held & !s_axi_bvalid & clk_en;
  wire logic [7:0] write_offset = 8'(aw_addr);
  wire logic write_lane = w_strb[0];
  wire logic write_mapped = (write_offset == OFFSET_RESTART_AND_DEADBAND) ||
                            (write_offset == OFFSET_SHUTDOWN_CONTROL) ||
                            (write_offset == OFFSET_IRQ_STATUS) ||
                            (write_offset == OFFSET_IRQ_MASK) ||
                            (write_offset == OFFSET_PIN_STATE);
  wire logic wr_deadband = write_fire & write_lane &
                           (write_offset == OFFSET_RESTART_AND_DEADBAND);
  wire logic wr_shutdown = write_fire & write_lane &
                           (write_offset == OFFSET_SHUTDOWN_CONTROL);
  wire logic wr_irq_status = write_fire & write_lane & (write_offset == OFFSET_IRQ_STATUS);
  wire logic wr_irq_mask = write_fire & write_lane & (write_offset == OFFSET_IRQ_MASK);

  assign s_axi_awready = !aw_held & clk_en;
  assign s_axi_wready  = !w_held & clk_en;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (write_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (write_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (clk_en) begin
      if (write_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= write_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Shutdown cause and status
  // ****************************************************************
  wire logic shutdown_cause = source_active(shutdown_source_select, shutdown_inputs);

  // Cause wins over any write, so neither software nor restart can clear it
  wire logic next_status = shutdown_cause ? 1'b1 :
                           wr_shutdown ? w_data[SHUTDOWN_STATUS_BIT] :
                           restart_enable ? 1'b0 :
                           shutdown_status;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_restart_and_deadband <= RESET_RESTART_DEADBAND;
      pwm_shutdown_control     <= RESET_SHUTDOWN_CONTROL;
    end else if (clk_en) begin
      if (wr_deadband) begin
        pwm_restart_and_deadband <= w_data[7:0];
      end
      if (wr_shutdown) begin
        pwm_shutdown_control[6:0] <= w_data[6:0];
      end
      pwm_shutdown_control[SHUTDOWN_STATUS_BIT] <= next_status;
    end
  end

  // ****************************************************************
  // Period-aligned hold
  // ****************************************************************
  // Status clearing mid-period must not restart modulation mid-period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_state <= RUNNING;
    end else if (clk_en) begin
      unique case (run_state)
        RUNNING: begin
          if (shutdown_status) begin
            run_state <= SHUT_DOWN;
          end
        end
        SHUT_DOWN: begin
          if (period_start && !shutdown_status && !shutdown_cause) begin
            run_state <= RUNNING;
          end
        end
      endcase
    end
  end

  // Cause is combinational so the pins react before any clock edge
  wire logic force_shutdown = shutdown_cause | shutdown_status |
                              (run_state == SHUT_DOWN);

  // ****************************************************************
  // Mode steering and dead band
  // ****************************************************************
  wire logic half_mode = (output_config_select == MODE_HALF_BRIDGE);
  logic      delayed_a;
  logic      delayed_b;

  deadband_delay #(
    .WIDTH      (DEADBAND_WIDTH)
  ) u_delay_a (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .clk_en     (clk_en),
    .enable     (half_mode),
    .count      (deadband_count),
    .active_in  (pwm_modulated),
    .active_out (delayed_a)
  );

  deadband_delay #(
    .WIDTH      (DEADBAND_WIDTH)
  ) u_delay_b (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .clk_en     (clk_en),
    .enable     (half_mode),
    .count      (deadband_count),
    .active_in  (!pwm_modulated),
    .active_out (delayed_b)
  );

  logic [3:0] next_normal;
  always_comb begin
    next_normal = 4'h0;
    unique case (output_config_select)
      MODE_SINGLE:       next_normal = {3'h0, pwm_modulated};
      MODE_HALF_BRIDGE:  next_normal = {2'h0, delayed_b, delayed_a};
      MODE_FULL_FORWARD: next_normal = {pwm_modulated, 2'h0, 1'b1};
      MODE_FULL_REVERSE: next_normal = {1'b0, 1'b1, pwm_modulated, 1'b0};
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      normal <= 4'h0;
    end else if (clk_en) begin
      normal <= next_normal;
    end
  end

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  logic [1:0] ac_level;
  logic [1:0] ac_oe_n;
  logic [1:0] bd_level;
  logic [1:0] bd_oe_n;

  pair_driver u_pair_ac (
    .normal         ({normal[2], normal[0]}),
    .invert         (output_polarity_select[1]),
    .force_shutdown (force_shutdown),
    .shutdown_state (pair_ac_shutdown_state),
    .level          (ac_level),
    .oe_n           (ac_oe_n)
  );

  pair_driver u_pair_bd (
    .normal         ({normal[3], normal[1]}),
    .invert         (output_polarity_select[0]),
    .force_shutdown (force_shutdown),
    .shutdown_state (pair_bd_shutdown_state),
    .level          (bd_level),
    .oe_n           (bd_oe_n)
  );

  assign bridge_pins.level = {bd_level[1], ac_level[1], bd_level[0], ac_level[0]};
  assign bridge_pins.oe_n  = {bd_oe_n[1], ac_oe_n[1], bd_oe_n[0], ac_oe_n[0]};

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  logic [IRQ_WIDTH-1:0] irq_events;
  assign irq_events[IRQ_SHUTDOWN_BIT] = next_status & !shutdown_status & clk_en;
  assign irq_events[IRQ_RESUME_BIT]   = (run_state == SHUT_DOWN) & period_start &
                                        !shutdown_status & !shutdown_cause & clk_en;

  // A new event beats a same-cycle write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= RESET_IRQ;
      irq_mask   <= RESET_IRQ;
    end else if (clk_en) begin
      irq_status <= (irq_status & ~({IRQ_WIDTH{wr_irq_status}} & w_data[IRQ_WIDTH-1:0]))
                    | irq_events;
      if (wr_irq_mask) begin
        irq_mask <= w_data[IRQ_WIDTH-1:0];
      end
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ****************************************************************
  // AXI4-Lite read path
  // ****************************************************************
  wire logic [7:0] read_offset = 8'(s_axi_araddr);
  logic [31:0] read_word;
  logic        read_ok;

  always_comb begin
    read_word = 32'h0;
    read_ok   = 1'b1;
    unique case (read_offset)
      OFFSET_RESTART_AND_DEADBAND: read_word = {24'h0, pwm_restart_and_deadband};
      OFFSET_SHUTDOWN_CONTROL:     read_word = {24'h0, pwm_shutdown_control};
      OFFSET_IRQ_STATUS:           read_word = {30'h0, irq_status};
      OFFSET_IRQ_MASK:             read_word = {30'h0, irq_mask};
      OFFSET_PIN_STATE:            read_word = {20'h0, run_state == SHUT_DOWN, force_shutdown,
                                                shutdown_cause, 1'b0, bridge_pins.oe_n,
                                                bridge_pins.level};
      default:                     read_ok   = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid & clk_en;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= read_word;
        s_axi_rresp  <= read_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_fall_immediate;
    clk_en && half_mode && !pwm_modulated |=> !normal[0];
  endproperty
  a_fall_immediate: assert property (p_fall_immediate)
    else $error("half-bridge A did not fall at once");

  property p_rise_delayed;
    clk_en && half_mode && $rose(pwm_modulated) && deadband_count != 7'h0 |-> !delayed_a;
  endproperty
  a_rise_delayed: assert property (p_rise_delayed)
    else $error("dead band not applied to rising edge");

  property p_async_force;
    shutdown_cause && pair_ac_shutdown_state == STATE_DRIVE_HIGH
      |-> bridge_pins.level[0] && bridge_pins.level[2];
  endproperty
  a_async_force: assert property (p_async_force)
    else $error("pins not forced in the cause cycle");

  property p_no_source;
    shutdown_source_select == 3'h0 |-> !shutdown_cause;
  endproperty
  a_no_source: assert property (p_no_source)
    else $error("shutdown without a selected source");

  property p_tristate;
    force_shutdown && pair_bd_shutdown_state[1] |-> bridge_pins.oe_n[1] && bridge_pins.oe_n[3];
  endproperty
  a_tristate: assert property (p_tristate)
    else $error("B/D pair not released");

  property p_status_set;
    clk_en && shutdown_cause |=> shutdown_status ##0 force_shutdown;
  endproperty
  a_status_set: assert property (p_status_set)
    else $error("status not set by cause");

  property p_auto_clear;
    clk_en && restart_enable && !shutdown_cause && !wr_shutdown |=> !shutdown_status;
  endproperty
  a_auto_clear: assert property (p_auto_clear)
    else $error("auto restart did not clear status");

  property p_sticky;
    clk_en && !restart_enable && shutdown_status && !wr_shutdown |=> shutdown_status;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("status cleared without software");

  property p_period_hold;
    run_state == SHUT_DOWN && !period_start |=> force_shutdown;
  endproperty
  a_period_hold: assert property (p_period_hold)
    else $error("modulation resumed mid-period");

  property p_write_ignored;
    clk_en && wr_shutdown && !w_data[SHUTDOWN_STATUS_BIT] && shutdown_cause |=> shutdown_status;
  endproperty
  a_write_ignored: assert property (p_write_ignored)
    else $error("status cleared while cause active");

  property p_force_write;
    clk_en && wr_shutdown && w_data[SHUTDOWN_STATUS_BIT] |=> force_shutdown [*2];
  endproperty
  a_force_write: assert property (p_force_write)
    else $error("software shutdown not applied");

endmodule : pwm_deadband_autoshutdown

// ### src/pwm_stage_pkg.sv
package pwm_stage_pkg;

  // ****************************************************************
  // Register map (byte addresses on the AXI4-Lite port)
  // ****************************************************************
  localparam logic [7:0] OFFSET_RESTART_AND_DEADBAND = 8'h00;
  localparam logic [7:0] OFFSET_SHUTDOWN_CONTROL     = 8'h04;
  localparam logic [7:0] OFFSET_IRQ_STATUS           = 8'h08;
  localparam logic [7:0] OFFSET_IRQ_MASK             = 8'h0c;
  localparam logic [7:0] OFFSET_PIN_STATE            = 8'h10;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int          DEADBAND_WIDTH        = 7;
  localparam int          RESTART_ENABLE_BIT    = 7;
  localparam int          SHUTDOWN_STATUS_BIT   = 7;
  localparam int          SOURCE_LSB            = 4;
  localparam int          PAIR_AC_LSB           = 2;
  localparam int          PAIR_BD_LSB           = 0;
  localparam int          IRQ_SHUTDOWN_BIT      = 0;
  localparam int          IRQ_RESUME_BIT        = 1;
  localparam int          IRQ_WIDTH             = 2;
  localparam logic [7:0]  RESET_RESTART_DEADBAND = 8'h00;
  localparam logic [7:0]  RESET_SHUTDOWN_CONTROL = 8'h00;
  localparam logic [1:0]  RESET_IRQ              = 2'h0;

  // ****************************************************************
  // Encodings
  // ****************************************************************
  localparam logic [1:0] MODE_SINGLE       = 2'h0;
  localparam logic [1:0] MODE_FULL_FORWARD = 2'h1;
  localparam logic [1:0] MODE_HALF_BRIDGE  = 2'h2;
  localparam logic [1:0] MODE_FULL_REVERSE = 2'h3;
  localparam logic [1:0] STATE_DRIVE_LOW   = 2'h0;
  localparam logic [1:0] STATE_DRIVE_HIGH  = 2'h1;
  localparam logic [1:0] RESP_OKAY         = 2'h0;
  localparam logic [1:0] RESP_SLVERR       = 2'h2;

  typedef enum logic {RUNNING, SHUT_DOWN} run_state_type;

  // Pins indexed A=0, B=1, C=2, D=3; oe_n low while driving
  typedef struct packed {
    logic [3:0] level;
    logic [3:0] oe_n;
  } bridge_pins_type;

  typedef struct packed {
    logic comparator1;
    logic comparator2;
    logic fault_input_pin;
  } shutdown_inputs_type;

  // Selected source level; codes 000 and 111 select nothing
  function automatic logic source_active(input logic [2:0] sel,
                                         input shutdown_inputs_type src);
    logic c1;
    logic c2;
    c1 = sel[0] & src.comparator1;
    c2 = sel[1] & src.comparator2;
    if (sel == 3'h7) begin
      source_active = 1'b0;
    end else if (sel[2]) begin
      source_active = src.fault_input_pin | c1 | c2;
    end else begin
      source_active = c1 | c2;
    end
  endfunction : source_active

endpackage : pwm_stage_pkg
